// ---- flash_host_pkg.sv ----
package flash_host_pkg;
  // bus timing in ns, converted to 20 MHz cycles
  localparam int clk_period_ns = 50;
  localparam int write_pulse_ns = 35;
  localparam int read_access_ns = 70;
  localparam int write_pulse_cycles =
    (write_pulse_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int read_access_cycles =
    (read_access_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int reset_pulse_ns = 500;
  localparam int reset_pulse_cycles =
    (reset_pulse_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int addr_width = 20;
  localparam int data_width = 16;
  localparam int poll_bit = 7;
  localparam int toggle_bit = 6;
  localparam int sector_count = 19;
  // unlock and command codes; plain defaults
  localparam logic [19:0] unlock_addr1 = 20'h00555;
  localparam logic [19:0] unlock_addr2 = 20'h002aa;
  localparam logic [15:0] unlock_data1 = 16'h00aa;
  localparam logic [15:0] unlock_data2 = 16'h0055;
  localparam logic [15:0] cmd_program = 16'h00a0;
  localparam logic [15:0] cmd_bypass_enter = 16'h0020;
  localparam logic [15:0] cmd_bypass_exit1 = 16'h0090;
  localparam logic [15:0] cmd_bypass_exit2 = 16'h0000;
  localparam logic [15:0] cmd_erase_setup = 16'h0080;
  localparam logic [15:0] cmd_chip_erase = 16'h0010;
  localparam logic [15:0] cmd_sector_erase = 16'h0030;
  localparam logic [15:0] cmd_suspend = 16'h00b0;
  localparam logic [15:0] cmd_resume = 16'h0030;
  localparam logic [15:0] cmd_reset = 16'h00f0;

  typedef enum logic [3:0] {
    op_read = 4'h0,
    op_program = 4'h1,
    op_chip_erase = 4'h2,
    op_sector_erase = 4'h3,
    op_suspend = 4'h4,
    op_resume = 4'h5,
    op_bypass_enter = 4'h6,
    op_bypass_exit = 4'h7,
    op_reset = 4'h8,
    op_hw_reset = 4'h9,
    op_standby = 4'ha
  } op_t;

  typedef struct packed {
    op_t op;
    logic [addr_width-1:0] addr;
    logic [data_width-1:0] data;
    logic [sector_count-1:0] sectors;
  } request_t;

  typedef struct packed {
    logic ce_b;
    logic we_b;
    logic oe_b;
    logic reset_b;
    logic byte_b;
    logic [addr_width-1:0] addr;
  } bus_pins_t;
endpackage

// ---- flash_bus_cycle.sv ----
`timescale 1ns/100ps
`default_nettype none
// one write or read cycle on the flash pins
module flash_bus_cycle #(
  parameter int pulse_cycles = flash_host_pkg::write_pulse_cycles,
  parameter int read_cycles = flash_host_pkg::read_access_cycles
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // request
  input wire logic start,
  input wire logic is_write,
  // pin strobes
  output logic we_b,
  output logic oe_b,
  output logic drive_en_b,
  output logic sample,
  output logic done
);
  localparam int cw = 8;
  logic [cw-1:0] count;
  logic active;
  logic writing;

  initial begin
    if (pulse_cycles < 1 || read_cycles < 1 || pulse_cycles > 200 ||
        read_cycles > 200) begin
      $error("bus cycle counts out of range");
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      active <= 1'b0;
      writing <= 1'b0;
      count <= '0;
      done <= 1'b0;
      sample <= 1'b0;
    end else begin
      done <= 1'b0;
      sample <= 1'b0;
      if (start && !active) begin
        active <= 1'b1;
        writing <= is_write;
        count <= is_write ? cw'(pulse_cycles) : cw'(read_cycles + 1);
      end else if (active) begin
        if (count == 8'h00) begin
          active <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 8'h01;
          if (!writing && count == 8'h01) begin
            sample <= 1'b1;
          end
        end
      end
    end
  end

  // strobes: we low for the pulse, data driven one cycle past it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      we_b <= 1'b1;
      oe_b <= 1'b1;
      drive_en_b <= 1'b1;
    end else begin
      we_b <= !(active && writing && count != 8'h00);
      oe_b <= !(active && !writing && count != 8'h00);
      drive_en_b <= !(active && writing);
    end
  end
endmodule
`default_nettype wire

// ---- flash_host_ctrl.sv ----
// Contract
// - host sends every operation except read, hardware reset and standby as write cycles to command register
// - in bypass mode one program takes two writes, otherwise four
// - busy shown on ready/busy pin and on poll and toggle bits
// - erase suspend holds erase; resume command continues it; host sends suspend only after erase completes and the model ignores it
// - host can place device into standby through control inputs
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl #(
  parameter int max_sectors = flash_host_pkg::sector_count
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // user request
  input wire logic req_valid,
  input wire flash_host_pkg::request_t req,
  input wire logic byte_mode,
  output logic req_ready,
  output logic rsp_valid,
  output logic [flash_host_pkg::data_width-1:0] rsp_data,
  output logic op_busy,
  output logic suspended,
  // flash pins
  output flash_host_pkg::bus_pins_t pins,
  output logic [flash_host_pkg::data_width-1:0] data_lane_wide_out,
  output logic data_lane_wide_oe_b,
  input wire logic [flash_host_pkg::data_width-1:0] data_lane_wide_in,
  input wire logic ready_busy_out
);
  typedef enum logic [6:0] {
    st_idle = 7'h01,
    st_write = 7'h02,
    st_read = 7'h04,
    st_wait = 7'h08,
    st_poll = 7'h10,
    st_reset = 7'h20,
    st_done = 7'h40
  } state_t;

  localparam int seq_max = 6 + flash_host_pkg::sector_count;
  state_t state;
  flash_host_pkg::request_t cur;
  logic [4:0] step;
  logic [4:0] seq_len;
  logic [4:0] sec_idx;
  logic bypass;
  logic [1:0] rb_sync;
  logic [7:0] rst_count;
  logic [flash_host_pkg::data_width-1:0] last_read;
  logic have_last;
  logic cyc_start;
  logic cyc_write;
  logic we_b;
  logic oe_b;
  logic drive_en_b;
  logic sample;
  logic cyc_done;
  logic [flash_host_pkg::addr_width-1:0] w_addr;
  logic [flash_host_pkg::data_width-1:0] w_data;

  initial begin
    if (max_sectors != flash_host_pkg::sector_count) begin
      $error("sector count must match the array map");
    end
  end

  flash_bus_cycle u_cycle (
    .clk(clk),
    .rst_b(rst_b),
    .start(cyc_start),
    .is_write(cyc_write),
    .we_b(we_b),
    .oe_b(oe_b),
    .drive_en_b(drive_en_b),
    .sample(sample),
    .done(cyc_done)
  );

  // k-th write of a command sequence
  function automatic logic [36:0] seq_word(
    input flash_host_pkg::request_t r, input logic byp,
    input logic [4:0] k, input logic [4:0] sec);
    logic [19:0] a;
    logic [15:0] d;
    a = flash_host_pkg::unlock_addr1;
    d = flash_host_pkg::unlock_data1;
    if (k == 5'd1 || k == 5'd4) begin
      a = flash_host_pkg::unlock_addr2;
      d = flash_host_pkg::unlock_data2;
    end
    case (r.op)
      flash_host_pkg::op_program: begin
        if (byp) begin
          if (k == 5'd0) d = flash_host_pkg::cmd_program;
          else begin
            a = r.addr;
            d = r.data;
          end
        end else if (k == 5'd2) d = flash_host_pkg::cmd_program;
        else if (k == 5'd3) begin
          a = r.addr;
          d = r.data;
        end
      end
      flash_host_pkg::op_chip_erase, flash_host_pkg::op_sector_erase: begin
        if (k == 5'd2) d = flash_host_pkg::cmd_erase_setup;
        else if (k == 5'd5) begin
          if (r.op == flash_host_pkg::op_chip_erase) begin
            d = flash_host_pkg::cmd_chip_erase;
          end else begin
            a = 20'(sec) << 15;
            d = flash_host_pkg::cmd_sector_erase;
          end
        end
      end
      flash_host_pkg::op_bypass_enter: begin
        if (k == 5'd2) d = flash_host_pkg::cmd_bypass_enter;
      end
      flash_host_pkg::op_bypass_exit: begin
        a = r.addr;
        d = (k == 5'd0) ? flash_host_pkg::cmd_bypass_exit1
                        : flash_host_pkg::cmd_bypass_exit2;
      end
      flash_host_pkg::op_suspend: d = flash_host_pkg::cmd_suspend;
      flash_host_pkg::op_resume: d = flash_host_pkg::cmd_resume;
      flash_host_pkg::op_reset: d = flash_host_pkg::cmd_reset;
      default: begin
        a = r.addr;
        d = 16'h0000;
      end
    endcase
    if (byte_mode) d = {8'h00, d[7:0]};
    return {1'b0, a, d};
  endfunction

  function automatic logic [4:0] seq_count(
    input flash_host_pkg::op_t op, input logic byp);
    case (op)
      flash_host_pkg::op_program: return byp ? 5'd2 : 5'd4;
      flash_host_pkg::op_chip_erase: return 5'd6;
      flash_host_pkg::op_sector_erase: return 5'd6;
      flash_host_pkg::op_bypass_enter: return 5'd3;
      flash_host_pkg::op_bypass_exit: return 5'd2;
      default: return 5'd1;
    endcase
  endfunction

  // next chosen sector at or above n; 31 when none
  function automatic logic [4:0] next_sector(
    input logic [flash_host_pkg::sector_count-1:0] s, input logic [4:0] n);
    logic [4:0] r;
    r = 5'd31;
    for (int i = flash_host_pkg::sector_count - 1; i >= 0; i--) begin
      if (s[i] && 5'(i) >= n) r = 5'(i);
    end
    return r;
  endfunction

  assign {w_addr, w_data} = 36'(seq_word(cur, bypass, step, sec_idx));
  assign cyc_write = (state == st_write);

  always_ff @(posedge clk) begin
    if (!rst_b) rb_sync <= 2'b00;
    else rb_sync <= {rb_sync[0], ready_busy_out};
  end

  // main sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= st_idle;
      cur <= '0;
      step <= '0;
      seq_len <= '0;
      sec_idx <= '0;
      cyc_start <= 1'b0;
      rst_count <= '0;
      have_last <= 1'b0;
      last_read <= '0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      req_ready <= 1'b0;
    end else begin
      cyc_start <= 1'b0;
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      case (state)
        st_idle: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            cur <= req;
            step <= '0;
            seq_len <= seq_count(req.op, bypass);
            sec_idx <= next_sector(req.sectors, 5'd0);
            case (req.op)
              flash_host_pkg::op_read: begin
                state <= st_read;
                cyc_start <= 1'b1;
              end
              flash_host_pkg::op_hw_reset: begin
                state <= st_reset;
                rst_count <= 8'(flash_host_pkg::reset_pulse_cycles);
              end
              flash_host_pkg::op_standby: state <= st_done;
              default: begin
                state <= st_write;
                cyc_start <= 1'b1;
              end
            endcase
          end
        end
        st_write: if (cyc_done) begin
          if (step + 5'd1 < seq_len) begin
            step <= step + 5'd1;
            cyc_start <= 1'b1;
          end else if (cur.op == flash_host_pkg::op_sector_erase &&
                       next_sector(cur.sectors, sec_idx + 5'd1) != 5'd31) begin
            sec_idx <= next_sector(cur.sectors, sec_idx + 5'd1);
            cyc_start <= 1'b1;
          end else if (cur.op == flash_host_pkg::op_program ||
                       cur.op == flash_host_pkg::op_chip_erase ||
                       cur.op == flash_host_pkg::op_sector_erase ||
                       cur.op == flash_host_pkg::op_resume) begin
            state <= st_wait;
            have_last <= 1'b0;
          end else state <= st_done;
        end
        st_wait: begin
          state <= st_poll;
          cyc_start <= 1'b1;
        end
        st_read, st_poll: if (sample) begin
          rsp_data <= data_lane_wide_in;
          if (state == st_read) begin
            rsp_valid <= 1'b1;
            state <= st_idle;
          end else begin
            last_read <= data_lane_wide_in;
            have_last <= 1'b1;
            // toggle bit stops toggling and ready pin high: done
            if (have_last && rb_sync[1] &&
                last_read[flash_host_pkg::toggle_bit] ==
                data_lane_wide_in[flash_host_pkg::toggle_bit]) begin
              state <= st_done;
            end else state <= st_wait;
          end
        end
        st_reset: begin
          if (rst_count == 8'h00) state <= st_done;
          else rst_count <= rst_count - 8'h01;
        end
        st_done: begin
          rsp_valid <= 1'b1;
          state <= st_idle;
        end
        default: state <= st_idle;
      endcase
    end
  end

  // bypass mode tracking and suspend status
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bypass <= 1'b0;
      suspended <= 1'b0;
      op_busy <= 1'b0;
    end else begin
      op_busy <= (state != st_idle);
      if (state == st_done) begin
        if (cur.op == flash_host_pkg::op_bypass_enter) bypass <= 1'b1;
        if (cur.op == flash_host_pkg::op_bypass_exit ||
            cur.op == flash_host_pkg::op_hw_reset) bypass <= 1'b0;
        if (cur.op == flash_host_pkg::op_suspend) suspended <= 1'b1;
        if (cur.op == flash_host_pkg::op_hw_reset) suspended <= 1'b0;
      end
      if (state == st_wait && cur.op == flash_host_pkg::op_resume) begin
        suspended <= 1'b0;
      end
    end
  end

  // pin drive; chip select and strobes are separate
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pins <= '{ce_b: 1'b1, we_b: 1'b1, oe_b: 1'b1, reset_b: 1'b0,
                byte_b: 1'b1, addr: '0};
      data_lane_wide_out <= '0;
      data_lane_wide_oe_b <= 1'b1;
    end else begin
      pins.we_b <= we_b;
      pins.oe_b <= oe_b;
      pins.ce_b <= (state == st_idle || state == st_done ||
                    state == st_reset);
      pins.reset_b <= (state != st_reset);
      pins.byte_b <= !byte_mode;
      pins.addr <= (state == st_read) ? cur.addr : w_addr;
      data_lane_wide_out <= w_data;
      data_lane_wide_oe_b <= drive_en_b;
    end
  end
endmodule
`default_nettype wire

// ---- flash_host_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module flash_host_checker #(
  parameter int max_sectors = flash_host_pkg::sector_count
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // user side
  input wire logic req_valid,
  input wire flash_host_pkg::request_t req,
  input wire logic byte_mode,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [flash_host_pkg::data_width-1:0] rsp_data,
  input wire logic op_busy,
  input wire logic suspended,
  // flash pins
  input wire flash_host_pkg::bus_pins_t pins,
  input wire logic [flash_host_pkg::data_width-1:0] data_lane_wide_out,
  input wire logic data_lane_wide_oe_b,
  input wire logic [flash_host_pkg::data_width-1:0] data_lane_wide_in,
  input wire logic ready_busy_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_we_drive;
    !pins.we_b |-> !pins.ce_b && !data_lane_wide_oe_b;
  endproperty
  a_we_drive: assert property (p_we_drive) else $error("bad write");
  property p_no_fight;
    !pins.oe_b |-> data_lane_wide_oe_b && pins.we_b && !pins.ce_b;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("fight");
  property p_we_pulse; $fell(pins.we_b) |=> pins.we_b; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("we width");
  property p_latch;
    !pins.we_b |=> $stable(pins.addr) && $stable(data_lane_wide_out);
  endproperty
  a_latch: assert property (p_latch) else $error("no hold");
  property p_hw_reset; $fell(pins.reset_b) |-> !pins.reset_b [*8]; endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("short");
  property p_take; req_valid && req_ready |=> !req_ready; endproperty
  a_take: assert property (p_take) else $error("second take");
  property p_idle; req_ready |-> !op_busy; endproperty
  a_idle: assert property (p_idle) else $error("ready busy");
  property p_done; rsp_valid |-> $past(ready_busy_out, 2); endproperty
  a_done: assert property (p_done) else $error("early done");
  property p_byte; !pins.we_b |-> pins.byte_b == !byte_mode; endproperty
  a_byte: assert property (p_byte) else $error("lane mode");
  property p_oe_hold; $fell(pins.oe_b) |-> !pins.oe_b [*2]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("oe short");
  cover property ($fell(pins.reset_b));
  cover property (!pins.we_b && byte_mode);
  cover property ($rose(ready_busy_out));
  cover property ($rose(suspended));
endmodule
bind flash_host_ctrl flash_host_checker #(.max_sectors(max_sectors)) chk_i (
  .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
  .byte_mode(byte_mode), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .op_busy(op_busy), .suspended(suspended),
  .pins(pins), .data_lane_wide_out(data_lane_wide_out),
  .data_lane_wide_oe_b(data_lane_wide_oe_b),
  .data_lane_wide_in(data_lane_wide_in), .ready_busy_out(ready_busy_out)
);
`default_nettype wire

// ---- flash_device_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module flash_device_model #(
  parameter int sleep_cycles = 30
) (
  // timing of the self-timed algorithms
  input wire logic clk,
  input wire logic slow,
  // protection and supply conditions
  input wire logic [18:0] locked,
  input wire logic unlock_hold,
  input wire logic low_supply,
  // flash pins
  input wire flash_host_pkg::bus_pins_t pins,
  input wire logic [15:0] data_lane_wide_out,
  input wire logic data_lane_wide_oe_b,
  output logic [15:0] data_lane_wide_in,
  output logic ready_busy_out
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] q = 16'h0000;
  logic [15:0] last = 16'hffff;
  logic [7:0] h1 = 8'h00;
  logic [7:0] h2 = 8'h00;
  logic [7:0] c;
  logic bypass = 0, pgm = 0, er = 0, ers = 0, tog = 0;
  int busy = 0;
  int wr_count = 0;
  int still = 0;
  logic [19:0] held = '0;
  logic asleep;
  // locked sectors refuse change unless the unprotect mode is held
  function automatic logic blocked(input logic [19:0] a);
    return a[19:15] < 5'd19 && locked[a[19:15]] && !unlock_hold;
  endfunction
  task automatic wipe(input logic [4:0] s);
    foreach (mem[k])
      if (k[19:15] == s && !blocked(k)) mem[k] = 16'hffff;
    busy = slow ? 60 : 20;
    last = 16'hffff;
  endtask
  always @(posedge pins.we_b) begin
    if (!pins.ce_b && pins.reset_b && !data_lane_wide_oe_b &&
        !low_supply) begin
      c = data_lane_wide_out[7:0];
      wr_count++;
      if (ers && c == flash_host_pkg::cmd_sector_erase[7:0])
        wipe(pins.addr[19:15]);
      else if (busy > 0) begin
      end else if (pgm) begin
        if (!blocked(pins.addr))
          mem[pins.addr] = pins.byte_b ? data_lane_wide_out
                                       : {8'hff, c};
        last = mem.exists(pins.addr) ? mem[pins.addr] : 16'hffff;
        pgm = 0;
        busy = slow ? 60 : 20;
      end else if (c == flash_host_pkg::cmd_reset[7:0])
        er = 0;
      else if (bypass && c == flash_host_pkg::cmd_program[7:0])
        pgm = 1;
      else if (bypass && h2 == flash_host_pkg::cmd_bypass_exit1[7:0] &&
          c == flash_host_pkg::cmd_bypass_exit2[7:0])
        bypass = 0;
      else if (h1 == flash_host_pkg::unlock_data1[7:0] &&
          h2 == flash_host_pkg::unlock_data2[7:0]) begin
        pgm = c == flash_host_pkg::cmd_program[7:0];
        if (c == flash_host_pkg::cmd_bypass_enter[7:0])
          bypass = 1;
        // chip erase clears every sector that is not locked
        if (er && c == flash_host_pkg::cmd_chip_erase[7:0]) begin
          foreach (mem[k])
            if (!blocked(k)) mem[k] = 16'hffff;
          busy = slow ? 60 : 20;
          last = 16'hffff;
        end
        if (er && c == flash_host_pkg::cmd_sector_erase[7:0]) begin
          ers = 1;
          wipe(pins.addr[19:15]);
        end
        er = c == flash_host_pkg::cmd_erase_setup[7:0];
      end
      h1 = h2;
      h2 = c;
    end
  end
  always @(posedge clk)
    if (!pins.reset_b) begin
      busy <= 0;
      pgm <= 0;
      er <= 0;
      ers <= 0;
      bypass <= 0;
      h2 <= 8'h00;
    end else if (busy > 0) begin
      busy <= busy - 1;
      ers <= ers && busy > 1;
    end
  always @(negedge pins.oe_b)
    if (busy > 0) tog = ~tog;
  // address held still for a while puts the array to sleep
  always @(posedge clk) begin
    held <= pins.addr;
    still <= pins.addr == held ? still + 1 : 0;
  end
  assign asleep = still >= sleep_cycles;
  // unselected lane shows a changing pattern, never the last value
  always @(negedge clk)
    if (!pins.ce_b && !pins.oe_b && pins.reset_b)
      q <= busy > 0 ? {8'h00, ~last[7], tog, 6'h00}
        : mem.exists(pins.addr) ? mem[pins.addr] : 16'hffff;
    else
      q <= ~q;
  assign data_lane_wide_in = q;
  assign ready_busy_out = busy == 0;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 0, rst_b = 0, req_valid = 0, byte_mode = 0, slow = 0;
  logic unlock_hold = 0, low_supply = 0, bsy;
  logic [18:0] locked = '0;
  flash_host_pkg::request_t req = '0;
  flash_host_pkg::bus_pins_t pins;
  logic req_ready, rsp_valid, op_busy, suspended, lane_oe_b, rdy;
  logic [15:0] rsp_data, lane_out, lane_in, q;
  int mismatches = 0, check_count = 0, n;
  always #25 clk = ~clk;
  flash_host_ctrl flash_host_ctrl_i (
    .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .byte_mode(byte_mode), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .op_busy(op_busy), .suspended(suspended),
    .pins(pins), .data_lane_wide_out(lane_out),
    .data_lane_wide_oe_b(lane_oe_b), .data_lane_wide_in(lane_in),
    .ready_busy_out(rdy)
  );
  flash_device_model flash_device_model_i (
    .clk(clk), .slow(slow), .locked(locked), .unlock_hold(unlock_hold),
    .low_supply(low_supply), .pins(pins), .data_lane_wide_out(lane_out),
    .data_lane_wide_oe_b(lane_oe_b), .data_lane_wide_in(lane_in),
    .ready_busy_out(rdy)
  );
  task automatic give_verdict;
    $display("mismatches=%0d checks=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic do_op(input flash_host_pkg::op_t op,
      input logic [19:0] a, input logic [15:0] d, input logic [18:0] s);
    int k;
    @(negedge clk);
    req = '{op, a, d, s};
    req_valid = 1;
    k = 0;
    while (req_ready !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (k == 100) mismatches++;
    @(negedge clk);
    req_valid = 0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    if (k == 2000) mismatches++;
    q = rsp_data;
    bsy = op_busy;
  endtask
  task automatic rd(input logic [19:0] a, input logic [15:0] e);
    do_op(flash_host_pkg::op_read, a, 16'h0000, '0);
    check(q, e);
    check(16'(bsy), 16'h0001);
  endtask
  // program, count the bus writes the device saw, read back
  task automatic pgm(input logic [19:0] a, input logic [15:0] d,
      input logic [15:0] w);
    n = flash_device_model_i.wr_count;
    do_op(flash_host_pkg::op_program, a, d, '0);
    check(16'(flash_device_model_i.wr_count - n), w);
    rd(a, d);
  endtask
  initial begin
    #2000000;
    mismatches++;
    give_verdict;
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1;
    repeat (3) @(negedge clk);
    check(16'(pins.reset_b), 16'h0001);
    check(16'(req_ready), 16'h0001);
    rd(20'h00100, 16'hffff);
    pgm(20'h00100, 16'h1234, 16'h0004);
    slow = 1;
    pgm(20'h08004, 16'ha5c3, 16'h0004);
    slow = 0;
    do_op(flash_host_pkg::op_bypass_enter, 20'h0, 16'h0, '0);
    pgm(20'h00101, 16'habcd, 16'h0002);
    pgm(20'h10002, 16'h5a5a, 16'h0002);
    do_op(flash_host_pkg::op_bypass_exit, 20'h0, 16'h0, '0);
    pgm(20'h00102, 16'h0f0f, 16'h0004);
    n = flash_device_model_i.wr_count;
    do_op(flash_host_pkg::op_sector_erase, 20'h0, 16'h0, 19'h00006);
    check(16'(flash_device_model_i.wr_count - n), 16'h0007);
    rd(20'h08004, 16'hffff);
    rd(20'h10002, 16'hffff);
    rd(20'h00100, 16'h1234);
    byte_mode = 1;
    do_op(flash_host_pkg::op_program, 20'h00200, 16'h1234, '0);
    byte_mode = 0;
    rd(20'h00200, 16'hff34);
    slow = 1;
    do_op(flash_host_pkg::op_chip_erase, 20'h0, 16'h0, '0);
    slow = 0;
    rd(20'h00100, 16'hffff);
    rd(20'h00200, 16'hffff);
    locked = 19'h00008;
    do_op(flash_host_pkg::op_program, 20'h18010, 16'h2222, '0);
    rd(20'h18010, 16'hffff);
    unlock_hold = 1;
    pgm(20'h18010, 16'h2222, 16'h0004);
    unlock_hold = 0;
    do_op(flash_host_pkg::op_sector_erase, 20'h0, 16'h0, 19'h00008);
    rd(20'h18010, 16'h2222);
    locked = '0;
    low_supply = 1;
    do_op(flash_host_pkg::op_program, 20'h00400, 16'h4321, '0);
    low_supply = 0;
    rd(20'h00400, 16'hffff);
    do_op(flash_host_pkg::op_bypass_enter, 20'h0, 16'h0, '0);
    do_op(flash_host_pkg::op_hw_reset, 20'h0, 16'h0, '0);
    pgm(20'h00300, 16'h7777, 16'h0004);
    do_op(flash_host_pkg::op_reset, 20'h0, 16'h0, '0);
    rd(20'h00300, 16'h7777);
    do_op(flash_host_pkg::op_suspend, 20'h0, 16'h0, '0);
    check(16'(suspended), 16'h0001);
    do_op(flash_host_pkg::op_resume, 20'h0, 16'h0, '0);
    check(16'(suspended), 16'h0000);
    do_op(flash_host_pkg::op_standby, 20'h0, 16'h0, '0);
    @(negedge clk);
    check(16'(pins.ce_b), 16'h0001);
    repeat (40) @(negedge clk);
    check(16'(flash_device_model_i.asleep), 16'h0001);
    give_verdict;
  end
endmodule
`default_nettype wire
